/* bench/host_sram_model.sv */
// Host processor model: strobes the watchdog and resolves the reset wire.
module host_sram_model (
   // Clock
   input wire logic clk_i,
   // Controls from the bench
   input wire logic strobe_en_i,
   input wire logic button_i,
   // Supervisor reset drive
   input wire logic reset_oe_i,
   input wire logic reset_data_i,
   // Wire levels
   output logic reset_wire_o,
   output logic strobe_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] tick;
   // The wire has a pull-up, so it rests high when nobody pulls it low.
   assign reset_wire_o = ((reset_oe_i && !reset_data_i) || button_i) ? 1'b0 : 1'b1;
   // Strobe low one cycle in ten, well inside the watchdog period.
   initial begin
      tick = 4'h0;
      strobe_n_o = 1'b1;
   end
   always @(posedge clk_i) begin
      tick <= (tick == 4'h9) ? 4'h0 : tick + 4'h1;
      strobe_n_o <= !(strobe_en_i && tick == 4'h0);
   end
endmodule : host_sram_model

/* bench/processor_supervisor_reset_tb.sv */
// Self-checking bench of the processor supervisor.
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end
module processor_supervisor_reset_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RHOLD = 20;
   localparam int WDOG = 50;
   logic clk, nrst, sup_ok, sup_sw, strobe_en, button, wire_lvl, strobe_n;
   logic oe, pin_o, lo_n, hi_n, batt;
   supervisor_pkg::ram_req_t req;
   int bad_count, num_checks, cycles, n, highs;
   logic [4:0] rows [5] = '{5'b000_00, 5'b001_01, 5'b010_10, 5'b100_11, 5'b011_11};
   // Short counts keep the whole run to a few hundred cycles.
   processor_supervisor_reset #(.RESET_HOLD(RHOLD), .WATCHDOG(WDOG), .DEBOUNCE(4)) u_dut (
      .CLK_I(clk), .NRST_I(nrst), .SUPPLY_ABOVE_2V88_I(sup_ok),
      .SUPPLY_ABOVE_SWITCH_I(sup_sw), .RESET_PIN_I(wire_lvl), .RESET_PIN_O(pin_o),
      .RESET_PIN_OE_O(oe), .WATCHDOG_STROBE_N_I(strobe_n),
      .RAM_SELECT_IN_N_I(req.ram_select_in_n), .UPPER_BYTE_ENABLE_N_I(req.upper_byte_enable_n),
      .LOWER_BYTE_ENABLE_N_I(req.lower_byte_enable_n), .RAM_SELECT_LOW_BYTE_N_O(lo_n),
      .RAM_SELECT_HIGH_BYTE_N_O(hi_n), .RAM_SUPPLY_FROM_BATTERY_O(batt));
   host_sram_model u_host (.clk_i(clk), .strobe_en_i(strobe_en), .button_i(button),
      .reset_oe_i(oe), .reset_data_i(pin_o), .reset_wire_o(wire_lvl), .strobe_n_o(strobe_n));
   // ---------------------------------------------------------------
   // Clock and hang guard
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // A hang is cut off far beyond the few hundred cycles the run needs.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         end_sim();
      end
   end
   // Waiting settles one step past the edge so outputs have landed.
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step
   task automatic wait_oe(input logic v, input int lim, output int cnt);
      cnt = 0;
      while (oe !== v && cnt < lim) begin
         step(1);
         cnt++;
      end
      `CHK(oe, v)
   endtask : wait_oe
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {nrst, strobe_en, button, bad_count, num_checks, cycles} = '0;
      {sup_ok, sup_sw} = 2'b11;
      req = 3'b111;
      step(5);
      `CHK({oe, pin_o, lo_n, hi_n, batt}, 5'b10110)
      @(posedge clk);
      nrst <= 1'b1;
      strobe_en <= 1'b1;
      wait_oe(1'b0, 200, n);
      `CHK(n >= RHOLD, 1'b1)
      foreach (rows[i]) begin
         @(posedge clk);
         req <= rows[i][4:2];
         step(4);
         `CHK({hi_n, lo_n}, rows[i][1:0])
      end
      // A healthy host strobing in time is never reset.
      highs = 0;
      repeat (150) begin
         step(1);
         if (oe !== 1'b0) highs++;
      end
      `CHK(highs, 0)
      @(posedge clk);
      sup_sw <= 1'b0;
      step(4);
      `CHK(batt, 1'b1)
      @(posedge clk);
      sup_sw <= 1'b1;
      req <= 3'b000;
      step(4);
      `CHK(batt, 1'b0)
      `CHK({hi_n, lo_n}, 2'b00)
      @(posedge clk);
      sup_ok <= 1'b0;
      step(3);
      `CHK(oe, 1'b1)
      `CHK({hi_n, lo_n}, 2'b11)
      @(posedge clk);
      sup_ok <= 1'b1;
      wait_oe(1'b0, 200, n);
      `CHK(n >= RHOLD, 1'b1)
      // A short press still yields a full-length reset pulse, timed from its rise.
      @(posedge clk);
      button <= 1'b1;
      wait_oe(1'b1, 20, n);
      `CHK(n >= 4, 1'b1)
      @(posedge clk);
      button <= 1'b0;
      wait_oe(1'b0, 200, n);
      `CHK(n + 1 >= RHOLD, 1'b1)
      @(posedge clk);
      strobe_en <= 1'b0;
      wait_oe(1'b1, WDOG + 10, n);
      `CHK(n >= WDOG - 12, 1'b1)
      end_sim();
   end
endmodule : processor_supervisor_reset_tb

/* design/processor_supervisor_reset.sv */
// Processor supervisor: power-fail reset, pushbutton, watchdog and SRAM gating.
module processor_supervisor_reset #(
   parameter longint RESET_HOLD = supervisor_pkg::RESET_HOLD_CYCLES,
   parameter longint WATCHDOG = supervisor_pkg::WATCHDOG_CYCLES,
   parameter int DEBOUNCE = supervisor_pkg::DEBOUNCE_CYCLES
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic NRST_I,
   // Analog comparator results (asynchronous)
   input wire logic SUPPLY_ABOVE_2V88_I,
   input wire logic SUPPLY_ABOVE_SWITCH_I,
   // Processor reset pin, open drain
   input wire logic RESET_PIN_I,
   output logic RESET_PIN_O,
   output logic RESET_PIN_OE_O,
   // Watchdog strobe
   input wire logic WATCHDOG_STROBE_N_I,
   // SRAM side
   input wire logic RAM_SELECT_IN_N_I,
   input wire logic UPPER_BYTE_ENABLE_N_I,
   input wire logic LOWER_BYTE_ENABLE_N_I,
   output logic RAM_SELECT_LOW_BYTE_N_O,
   output logic RAM_SELECT_HIGH_BYTE_N_O,
   output logic RAM_SUPPLY_FROM_BATTERY_O
);

   localparam int CW = supervisor_pkg::CNT_W;
   localparam logic [CW-1:0] HOLD_END = CW'(RESET_HOLD - 1);
   localparam logic [CW-1:0] WDOG_END = CW'(WATCHDOG - 1);
   localparam logic [CW-1:0] DEB_END = CW'(DEBOUNCE - 1);

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [6:0] sync1;
   logic [6:0] sync2;
   logic [6:0] async_in;
   assign async_in = {SUPPLY_ABOVE_2V88_I, SUPPLY_ABOVE_SWITCH_I, RESET_PIN_I,
                      WATCHDOG_STROBE_N_I, RAM_SELECT_IN_N_I, UPPER_BYTE_ENABLE_N_I,
                      LOWER_BYTE_ENABLE_N_I};

   // Two stages per pin; only the second stage is read by logic.
   // Stages reset to each pin's idle level (supply not yet good, switch
   // comparator high, active-low pins released), so no false press, strobe
   // or battery switch shows up right after reset.
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         sync1 <= 7'h3f;
         sync2 <= 7'h3f;
      end else begin
         sync1 <= async_in;
         sync2 <= sync1;
      end
   end

   supervisor_pkg::supply_t supply;
   supervisor_pkg::ram_req_t ram_req;
   logic pin_level;
   logic strobe_n;
   assign supply.supply_ok = sync2[6];
   assign supply.battery_select = ~sync2[5];
   assign pin_level = sync2[4];
   assign strobe_n = sync2[3];
   assign ram_req = sync2[2:0];

   // ---------------------------------------------------------------
   // Reset sequencer
   // ---------------------------------------------------------------
   supervisor_pkg::sup_state_t state;
   logic [CW-1:0] hold_cnt;
   logic [CW-1:0] wdog_cnt;
   logic [CW-1:0] deb_cnt;
   logic press_ok;
   logic wdog_expire;
   logic own_drive;
   logic [1:0] oe_hist;

   // Our own pull on the wire needs two synchroniser stages to fade from the
   // sensed level, so the button stays blanked for them; otherwise a short
   // debounce would take the tail of our own pulse for a fresh press.
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         oe_hist <= 2'h3;
      end else begin
         oe_hist <= {oe_hist[0], RESET_PIN_OE_O};
      end
   end

   // Pushbutton debounce; the pin is ignored while we drive it ourselves,
   // otherwise our own pulse would retrigger itself forever.
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         deb_cnt <= '0;
      end else if (pin_level || own_drive) begin
         deb_cnt <= '0;
      end else if (deb_cnt != DEB_END) begin
         deb_cnt <= deb_cnt + CW'(1);
      end
   end
   assign press_ok = (deb_cnt == DEB_END) && !own_drive;

   // Watchdog runs only while the processor is out of reset.
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         wdog_cnt <= '0;
      end else if (state != supervisor_pkg::ST_RUN || !strobe_n) begin
         wdog_cnt <= '0;
      end else if (wdog_cnt != WDOG_END) begin
         wdog_cnt <= wdog_cnt + CW'(1);
      end
   end
   assign wdog_expire = (wdog_cnt == WDOG_END) && strobe_n;

   // Power fail wins over everything; hold counts the 250ms interval.
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state <= supervisor_pkg::ST_POWER_FAIL;
         hold_cnt <= '0;
      end else begin
         case (state)
            supervisor_pkg::ST_POWER_FAIL: begin
               hold_cnt <= '0;
               if (supply.supply_ok) begin
                  state <= supervisor_pkg::ST_HOLD;
               end
            end
            supervisor_pkg::ST_HOLD: begin
               if (!supply.supply_ok) begin
                  state <= supervisor_pkg::ST_POWER_FAIL;
               end else if (hold_cnt == HOLD_END) begin
                  state <= supervisor_pkg::ST_RUN;
               end else begin
                  hold_cnt <= hold_cnt + CW'(1);
               end
            end
            supervisor_pkg::ST_RUN: begin
               hold_cnt <= '0;
               if (!supply.supply_ok) begin
                  state <= supervisor_pkg::ST_POWER_FAIL;
               end else if (press_ok || wdog_expire) begin
                  state <= supervisor_pkg::ST_HOLD;
               end
            end
            default: begin
               state <= supervisor_pkg::ST_POWER_FAIL;
               hold_cnt <= '0;
            end
         endcase
      end
   end
   assign own_drive = (state != supervisor_pkg::ST_RUN) || RESET_PIN_OE_O ||
                      (oe_hist != 2'h0);

   // ---------------------------------------------------------------
   // Outputs, all registered
   // ---------------------------------------------------------------
   // Open drain: output value is always low, only the enable moves.
   // The power-fail term goes straight to the enable so it acts one
   // clock earlier than the state register alone would.
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         RESET_PIN_O <= 1'b0;
         RESET_PIN_OE_O <= 1'b1;
      end else begin
         RESET_PIN_O <= 1'b0;
         RESET_PIN_OE_O <= !supply.supply_ok || !(state == supervisor_pkg::ST_RUN &&
                           !press_ok && !wdog_expire);
      end
   end

   // SRAM gating; enables blocked whenever the supply is bad.
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         RAM_SELECT_LOW_BYTE_N_O <= 1'b1;
         RAM_SELECT_HIGH_BYTE_N_O <= 1'b1;
         RAM_SUPPLY_FROM_BATTERY_O <= 1'b0;
      end else begin
         RAM_SELECT_LOW_BYTE_N_O <= !(supply.supply_ok && !ram_req.ram_select_in_n &&
                                    !ram_req.lower_byte_enable_n);
         RAM_SELECT_HIGH_BYTE_N_O <= !(supply.supply_ok && !ram_req.ram_select_in_n &&
                                     !ram_req.upper_byte_enable_n);
         RAM_SUPPLY_FROM_BATTERY_O <= supply.battery_select;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_fail_reset: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !supply.supply_ok |=> RESET_PIN_OE_O)
      else $error("reset not asserted on supply failure");
   chk_ram_block: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !supply.supply_ok |=> RAM_SELECT_LOW_BYTE_N_O && RAM_SELECT_HIGH_BYTE_N_O)
      else $error("sram enabled during power failure");
   chk_hold_entry: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      state == supervisor_pkg::ST_POWER_FAIL && supply.supply_ok
      |=> state == supervisor_pkg::ST_HOLD && hold_cnt == '0)
      else $error("hold interval not started");
   chk_hold_len: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      state == supervisor_pkg::ST_HOLD && hold_cnt != HOLD_END && supply.supply_ok
      |=> state == supervisor_pkg::ST_HOLD && hold_cnt == $past(hold_cnt) + CW'(1))
      else $error("hold ended early");
   chk_press_reset: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      state == supervisor_pkg::ST_RUN && press_ok && supply.supply_ok
      |=> state == supervisor_pkg::ST_HOLD ##1 RESET_PIN_OE_O)
      else $error("pushbutton did not reset");
   chk_wdog_reset: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      state == supervisor_pkg::ST_RUN && wdog_expire && supply.supply_ok
      |=> RESET_PIN_OE_O && state == supervisor_pkg::ST_HOLD)
      else $error("watchdog expiry did not reset");
   chk_strobe_clr: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !strobe_n |=> wdog_cnt == '0)
      else $error("strobe did not restart watchdog");
   chk_ram_pass: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      supply.supply_ok && !ram_req.ram_select_in_n && !ram_req.upper_byte_enable_n
      |=> !RAM_SELECT_HIGH_BYTE_N_O)
      else $error("high byte enable not passed");
   chk_ram_select: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      ram_req.ram_select_in_n |=> RAM_SELECT_LOW_BYTE_N_O && RAM_SELECT_HIGH_BYTE_N_O)
      else $error("sram enabled without select");
   chk_battery_sw: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      ##1 RAM_SUPPLY_FROM_BATTERY_O == $past(supply.battery_select))
      else $error("sram supply not following comparator");
   chk_pin_low: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      RESET_PIN_O == 1'b0)
      else $error("reset pin driven high");

endmodule : processor_supervisor_reset

/* design/supervisor_pkg.sv */
// Package with timing constants and signal groups of the processor supervisor.
package supervisor_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam longint RESET_HOLD_MS = 250;
   localparam longint RESET_HOLD_CYCLES = RESET_HOLD_MS * 1000000000 / CLK_PERIOD_PS;
   localparam longint WATCHDOG_MS = 1000;
   localparam longint WATCHDOG_CYCLES = WATCHDOG_MS * 1000000000 / CLK_PERIOD_PS;
   localparam int DEBOUNCE_CYCLES = 16;
   localparam int CNT_W = 32;

   // ---------------------------------------------------------------
   // Signal groups
   // ---------------------------------------------------------------
   typedef struct packed {
      logic ram_select_in_n;
      logic upper_byte_enable_n;
      logic lower_byte_enable_n;
   } ram_req_t;

   typedef struct packed {
      logic supply_ok;
      logic battery_select;
   } supply_t;

   typedef enum logic [2:0] {
      ST_POWER_FAIL = 3'b001,
      ST_HOLD = 3'b010,
      ST_RUN = 3'b100
   } sup_state_t;

endpackage : supervisor_pkg
